// >>> common/ats_consts.vh
// constants for the address translation select block
// How it works
// RULE1 - translation off: physical equals effective address
// RULE2 - block hit checked against its protection bits
// RULE3 - block hit overrides parallel page translation
// RULE4 - top four address bits pick segment
// RULE5 - non direct-store segment forms 52-bit virtual address
// RULE6 - direct-store segments fault, fetch bit3, data bit5
// RULE7 - no-execute segment fetch faults with bit3
// RULE8 - separate instruction and data translation caches
// RULE9 - cache miss searches table, allocates, retries
// RULE10 - protection violation sets cause bit4
// RULE11 - no table entry, no block: bit1
// RULE12 - guarded fetch with translation faults bit3
// RULE13 - data translation off: no storage faults
// RULE14 - fault reports failing instruction address
// RULE15 - one fault per access, fixed priority
`ifndef ATS_CONSTS_VH
`define ATS_CONSTS_VH

// segment register fields
`define ATS_SEG_T       31
`define ATS_SEG_KS      30
`define ATS_SEG_KP      29
`define ATS_SEG_N       28
`define ATS_SEG_VSID    23:0
`define ATS_SEG_SEL     31:28
// block map upper word fields
`define ATS_BMU_EPI     31:17
`define ATS_BMU_LEN     12:2
`define ATS_BMU_VS      1
`define ATS_BMU_VP      0
// block map lower word fields
`define ATS_BML_RPN     31:17
`define ATS_BML_G       3
`define ATS_BML_PP      1:0
// effective address slices
`define ATS_EA_BLK      31:17
`define ATS_EA_BOFF     16:0
`define ATS_EA_PIDX     27:12
`define ATS_EA_POFF     11:0
// cause bit positions, big-endian numbering: printed bit n sits at 31-n
`define ATS_CB_PF       30
`define ATS_CB_NX       28
`define ATS_CB_PROT     27
`define ATS_CB_DS       26
// protection encodings
`define ATS_PP_NONE     2'h0
`define ATS_PP_RW       2'h2
`define ATS_PP_RO_KEY0  2'h3
// reset values
`define ATS_ZERO32      32'h0000_0000
`define ATS_ZERO52      52'h0_0000_0000_0000
// sizes
`define ATS_NSEG        16
`define ATS_NBLK        4
`define ATS_NTLB        4

`endif

// >>> design/ats_tlb.v
// fully associative translation cache with round-robin refill
`timescale 1ns/10ps
`include "ats_consts.vh"
module ats_tlb (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rstn_i,
  // lookup
  input  wire [39:0] look_vpn_i,
  output reg         hit_o,
  output reg  [19:0] rpn_o,
  output reg         g_o,
  output reg  [1:0]  pp_o,
  // refill
  input  wire        wr_i,
  input  wire [39:0] wr_vpn_i,
  input  wire [19:0] wr_rpn_i,
  input  wire        wr_g_i,
  input  wire [1:0]  wr_pp_i
);
  reg  [`ATS_NTLB-1:0] vld;               // entry valid
  reg  [39:0]          tag [0:`ATS_NTLB-1]; // virtual page number
  reg  [19:0]          rpn [0:`ATS_NTLB-1]; // real page number
  reg  [`ATS_NTLB-1:0] gbit;              // page guarded flag
  reg  [1:0]           pp  [0:`ATS_NTLB-1]; // page protection
  reg  [1:0]           victim;            // next slot to refill
  wire [`ATS_NTLB-1:0] match;             // per-entry compare
  integer              k;

  genvar e;
  generate
    for (e = 0; e < `ATS_NTLB; e = e + 1) begin : g_ent
      localparam integer SLOT = e; // slot number compared with the refill pointer
      assign match[e] = vld[e] && (tag[e] == look_vpn_i);
      // entry storage, refilled only at the victim slot
      always @(posedge ref_clk_i) begin
        if (!rstn_i) begin
          tag[e] <= 40'h00_0000_0000;
          rpn[e] <= 20'h0_0000;
          pp[e]  <= 2'h0;
        end else if (wr_i && victim == SLOT[1:0]) begin // RULE9
          tag[e] <= wr_vpn_i;
          rpn[e] <= wr_rpn_i;
          pp[e]  <= wr_pp_i;
        end
      end
    end
  endgenerate

  // valid bits, guarded bits and replacement pointer
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      vld    <= 4'h0;
      gbit   <= 4'h0;
      victim <= 2'h0;
    end else if (wr_i) begin
      vld[victim]  <= 1'b1;
      gbit[victim] <= wr_g_i;
      victim       <= victim + 2'h1;
    end
  end

  // hit select; refill never duplicates a tag, so at most one matches
  always @* begin
    hit_o = 1'b0;
    rpn_o = 20'h0_0000;
    g_o   = 1'b0;
    pp_o  = 2'h0;
    for (k = 0; k < `ATS_NTLB; k = k + 1) begin
      if (match[k]) begin
        hit_o = 1'b1; // RULE8
        rpn_o = rpn[k];
        g_o   = gbit[k];
        pp_o  = pp[k];
      end
    end
  end
endmodule // ats_tlb

// >>> design/ats_top.v
// translation path select and storage fault classification
`timescale 1ns/10ps
`include "ats_consts.vh"
module ats_top (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rstn_i,
  // translation enables
  input  wire        instr_translate_enable_i,
  input  wire        data_translate_enable_i,
  // access request
  input  wire        req_valid_i,
  output wire        req_ready_o,
  input  wire        req_fetch_i,
  input  wire        req_store_i,
  input  wire        req_user_i,
  input  wire [31:0] req_ea_i,
  input  wire [31:0] req_pc_i,
  // segment register load
  input  wire        seg_wr_i,
  input  wire [3:0]  seg_idx_i,
  input  wire [31:0] seg_data_i,
  // block map load, idx[2] selects data side
  input  wire        blk_wr_i,
  input  wire [2:0]  blk_idx_i,
  input  wire [31:0] blk_upper_i,
  input  wire [31:0] blk_lower_i,
  // page table search port
  output wire        pt_req_o,
  output wire [39:0] pt_vpn_o,
  input  wire        pt_ack_i,
  input  wire        pt_found_i,
  input  wire [19:0] pt_rpn_i,
  input  wire        pt_g_i,
  input  wire [1:0]  pt_pp_i,
  // answer
  output reg         resp_valid_o,
  output reg  [31:0] resp_pa_o,
  output reg  [51:0] resp_va_o,
  output reg         instr_storage_fault_o,
  output reg         data_storage_fault_o,
  output reg  [31:0] saved_status_reg_o,
  output reg  [31:0] data_fault_cause_reg_o,
  output reg  [31:0] fault_pc_o
);
  // states
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_CHECK = 2'h1;
  localparam [1:0] ST_WALK  = 2'h2;

  reg  [1:0]  state;                        // walker state
  reg         r_fetch;                      // held access kind
  reg         r_store;
  reg         r_user;
  reg  [31:0] r_ea;                         // held effective address
  reg  [31:0] r_pc;                         // held instruction address
  reg  [31:0] seg [0:`ATS_NSEG-1];          // segment registers
  reg  [31:0] bmu [0:2*`ATS_NBLK-1];        // block map upper words
  reg  [31:0] bml [0:2*`ATS_NBLK-1];        // block map lower words
  wire [7:0]  bm_hit;                       // per-entry block match
  wire [31:0] bm_pa [0:7];                  // per-entry block address
  reg         blk_hit;                      // selected block result
  reg  [31:0] blk_pa;
  reg         blk_g;
  reg  [1:0]  blk_pp;
  integer     k;
  integer     j;                            // reset loop index, kept apart from k

  // segment and translation cache signals
  wire [31:0] sd     = seg[r_ea[`ATS_SEG_SEL]];                        // RULE4
  wire [51:0] va     = {sd[`ATS_SEG_VSID], r_ea[27:0]};                // RULE5
  wire        key    = r_user ? sd[`ATS_SEG_KP] : sd[`ATS_SEG_KS];
  wire        xlate  = r_fetch ? instr_translate_enable_i : data_translate_enable_i;
  wire        i_hit, d_hit;
  wire [19:0] i_rpn, d_rpn;
  wire        i_g, d_g;
  wire [1:0]  i_pp, d_pp;
  wire        tlb_hit = r_fetch ? i_hit : d_hit;                       // RULE8
  wire [19:0] tlb_rpn = r_fetch ? i_rpn : d_rpn;
  wire        tlb_g   = r_fetch ? i_g : d_g;
  wire [1:0]  tlb_pp  = r_fetch ? i_pp : d_pp;
  wire        refill  = (state == ST_WALK) && pt_ack_i && pt_found_i;

  // block protection: none, read-only on odd codes, read/write on 2
  wire blk_viol = (blk_pp == `ATS_PP_NONE) || (r_store && blk_pp[0]);
  // page protection from key and page bits
  wire pg_viol  = key ? ((tlb_pp == `ATS_PP_NONE) || (r_store && tlb_pp[0]))
                      : (r_store && (tlb_pp == `ATS_PP_RO_KEY0));

  assign req_ready_o = (state == ST_IDLE);
  assign pt_req_o    = (state == ST_WALK);                             // RULE9
  assign pt_vpn_o    = va[51:12];

  // instruction and data translation caches
  ats_tlb u_itlb (
    .ref_clk_i  (ref_clk_i),
    .rstn_i     (rstn_i),
    .look_vpn_i (va[51:12]),
    .hit_o      (i_hit),
    .rpn_o      (i_rpn),
    .g_o        (i_g),
    .pp_o       (i_pp),
    .wr_i       (refill && r_fetch),
    .wr_vpn_i   (va[51:12]),
    .wr_rpn_i   (pt_rpn_i),
    .wr_g_i     (pt_g_i),
    .wr_pp_i    (pt_pp_i)
  );
  ats_tlb u_dtlb (
    .ref_clk_i  (ref_clk_i),
    .rstn_i     (rstn_i),
    .look_vpn_i (va[51:12]),
    .hit_o      (d_hit),
    .rpn_o      (d_rpn),
    .g_o        (d_g),
    .pp_o       (d_pp),
    .wr_i       (refill && !r_fetch),
    .wr_vpn_i   (va[51:12]),
    .wr_rpn_i   (pt_rpn_i),
    .wr_g_i     (pt_g_i),
    .wr_pp_i    (pt_pp_i)
  );

  // per-entry block compare, length mask frees low block bits
  genvar e;
  generate
    for (e = 0; e < 2 * `ATS_NBLK; e = e + 1) begin : g_blk
      wire [14:0] msk = {4'h0, bmu[e][`ATS_BMU_LEN]};
      wire        vok = r_user ? bmu[e][`ATS_BMU_VP] : bmu[e][`ATS_BMU_VS];
      assign bm_hit[e] = vok && ((r_ea[`ATS_EA_BLK] & ~msk) ==
                                 (bmu[e][`ATS_BMU_EPI] & ~msk));
      assign bm_pa[e]  = {(bml[e][`ATS_BML_RPN] & ~msk) | (r_ea[`ATS_EA_BLK] & msk),
                          r_ea[`ATS_EA_BOFF]};
    end
  endgenerate

  // pick the lowest matching entry of the access's own side
  always @* begin
    blk_hit = 1'b0;
    blk_pa  = `ATS_ZERO32;
    blk_g   = 1'b0;
    blk_pp  = 2'h0;
    for (k = `ATS_NBLK - 1; k >= 0; k = k - 1) begin
      if (bm_hit[r_fetch ? k : k + `ATS_NBLK]) begin
        blk_hit = 1'b1;
        blk_pa  = bm_pa[r_fetch ? k : k + `ATS_NBLK];
        blk_g   = bml[r_fetch ? k : k + `ATS_NBLK][`ATS_BML_G];
        blk_pp  = bml[r_fetch ? k : k + `ATS_NBLK][`ATS_BML_PP];
      end
    end
  end

  // segment and block map loads; software keeps them stable per access
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      for (j = 0; j < `ATS_NSEG; j = j + 1)
        seg[j] <= `ATS_ZERO32;
      for (j = 0; j < 2 * `ATS_NBLK; j = j + 1) begin
        bmu[j] <= `ATS_ZERO32;
        bml[j] <= `ATS_ZERO32;
      end
    end else begin
      if (seg_wr_i)
        seg[seg_idx_i] <= seg_data_i;
      if (blk_wr_i) begin
        bmu[blk_idx_i] <= blk_upper_i;
        bml[blk_idx_i] <= blk_lower_i;
      end
    end
  end

  // fault sink: one cause at a time, set on the correct side only
  task report;
    input [31:0] pa;
    input [4:0]  cause; // bit order: pf, nx, prot, ds, any
    begin
      resp_valid_o           <= 1'b1;
      resp_pa_o              <= pa;
      resp_va_o              <= va;
      instr_storage_fault_o  <= cause[0] && r_fetch;
      data_storage_fault_o   <= cause[0] && !r_fetch;
      saved_status_reg_o     <= `ATS_ZERO32;
      data_fault_cause_reg_o <= `ATS_ZERO32;
      fault_pc_o             <= cause[0] ? r_pc : `ATS_ZERO32;         // RULE14
      if (r_fetch) begin
        saved_status_reg_o[`ATS_CB_PF]   <= cause[4];
        saved_status_reg_o[`ATS_CB_NX]   <= cause[3] | cause[1];
        saved_status_reg_o[`ATS_CB_PROT] <= cause[2];
      end else begin
        data_fault_cause_reg_o[`ATS_CB_PF]   <= cause[4];
        data_fault_cause_reg_o[`ATS_CB_PROT] <= cause[2];
        data_fault_cause_reg_o[`ATS_CB_DS]   <= cause[1];
      end
    end
  endtask

  // control: accept, classify, walk on miss, answer once
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      state                  <= ST_IDLE;
      r_fetch                <= 1'b0;
      r_store                <= 1'b0;
      r_user                 <= 1'b0;
      r_ea                   <= `ATS_ZERO32;
      r_pc                   <= `ATS_ZERO32;
      resp_valid_o           <= 1'b0;
      resp_pa_o              <= `ATS_ZERO32;
      resp_va_o              <= `ATS_ZERO52;
      instr_storage_fault_o  <= 1'b0;
      data_storage_fault_o   <= 1'b0;
      saved_status_reg_o     <= `ATS_ZERO32;
      data_fault_cause_reg_o <= `ATS_ZERO32;
      fault_pc_o             <= `ATS_ZERO32;
    end else begin
      resp_valid_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_valid_i) begin
            r_fetch <= req_fetch_i;
            r_store <= req_store_i && !req_fetch_i;
            r_user  <= req_user_i;
            r_ea    <= req_ea_i;
            r_pc    <= req_pc_i;
            state   <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          state <= ST_IDLE;
          // priority: real mode, block, direct-store, no-execute,
          // then page guarded, protection, walk
          if (!xlate)
            report(r_ea, 5'h00);                                       // RULE1 RULE13
          else if (blk_hit) begin                                      // RULE3
            if (r_fetch && blk_g)
              report(blk_pa, 5'h03);                                   // RULE12 RULE15
            else if (blk_viol)
              report(blk_pa, 5'h05);                                   // RULE2 RULE10
            else
              report(blk_pa, 5'h00);
          end else if (sd[`ATS_SEG_T])
            report(r_ea, 5'h03);                                       // RULE6
          else if (r_fetch && sd[`ATS_SEG_N])
            report(r_ea, 5'h09);                                       // RULE7
          else if (tlb_hit) begin
            if (r_fetch && tlb_g)
              report({tlb_rpn, r_ea[`ATS_EA_POFF]}, 5'h03);            // RULE12
            else if (pg_viol)
              report({tlb_rpn, r_ea[`ATS_EA_POFF]}, 5'h05);            // RULE10
            else
              report({tlb_rpn, r_ea[`ATS_EA_POFF]}, 5'h00);            // RULE8
          end else
            state <= ST_WALK;                                          // RULE9
        end
        ST_WALK: begin
          // found: refill is written this edge, retry hits next cycle
          if (pt_ack_i) begin
            if (pt_found_i)
              state <= ST_CHECK;                                       // RULE9
            else begin
              report(r_ea, 5'h11);                                     // RULE11
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // ats_top

// >>> sim/ats_monitor.sv
// port checker for the translation select block
`timescale 1ns/10ps
module ats_monitor (
  // clock and reset
  input wire        ref_clk_i,
  input wire        rstn_i,
  // request side
  input wire        instr_translate_enable_i,
  input wire        data_translate_enable_i,
  input wire        req_valid_i,
  input wire        req_ready_o,
  input wire        req_fetch_i,
  input wire [31:0] req_ea_i,
  input wire [31:0] req_pc_i,
  // table search and answer
  input wire        pt_req_o,
  input wire [39:0] pt_vpn_o,
  input wire        pt_ack_i,
  input wire        resp_valid_o,
  input wire [31:0] resp_pa_o,
  input wire        instr_storage_fault_o,
  input wire        data_storage_fault_o,
  input wire [31:0] saved_status_reg_o,
  input wire [31:0] data_fault_cause_reg_o,
  input wire [31:0] fault_pc_o
);
  reg        t_f;  // access in flight is a fetch
  reg [31:0] t_ea; // its effective address
  reg [31:0] t_pc; // its instruction address
  wire       isf = instr_storage_fault_o;
  wire       dsf = data_storage_fault_o;
  // enables are held steady by the core, so reading them late is safe
  wire t_off = t_f ? !instr_translate_enable_i : !data_translate_enable_i;
  // capture the access on its taking edge
  always @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      t_f  <= 1'b0;
      t_ea <= 32'h0000_0000;
      t_pc <= 32'h0000_0000;
    end else if (req_valid_i && req_ready_o) begin
      t_f  <= req_fetch_i;
      t_ea <= req_ea_i;
      t_pc <= req_pc_i;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  a_taken_busy: assert property (req_valid_i && req_ready_o |=> !req_ready_o)
    else $error("ready stayed high after a take");
  a_real_pa: assert property (resp_valid_o && t_off |-> resp_pa_o == t_ea && !isf && !dsf)
    else $error("real mode answer wrong");
  a_fault_side: assert property (resp_valid_o |-> !(isf && !t_f) && !(dsf && t_f))
    else $error("fault on wrong side");
  a_fault_pc: assert property (resp_valid_o && (isf || dsf) |-> fault_pc_o == t_pc)
    else $error("fault address wrong");
  a_isf_cause: assert property (resp_valid_o && isf |->
    $onehot(saved_status_reg_o) && (saved_status_reg_o & 32'hA7FF_FFFF) == 32'h0000_0000)
    else $error("fetch fault cause bad");
  a_dsf_cause: assert property (resp_valid_o && dsf |->
    $onehot(data_fault_cause_reg_o) && (data_fault_cause_reg_o & 32'hB3FF_FFFF) == 0)
    else $error("data fault cause bad");
  a_clean_ok: assert property (resp_valid_o && !isf && !dsf |->
    saved_status_reg_o == 0 && data_fault_cause_reg_o == 0 && fault_pc_o == 0)
    else $error("status set without fault");
  a_walk_vpn: assert property (pt_req_o |-> pt_vpn_o[15:0] == t_ea[27:12])
    else $error("search page index wrong");
  a_walk_hold: assert property (pt_req_o && !pt_ack_i |=> pt_req_o && $stable(pt_vpn_o))
    else $error("search dropped early");
  a_walk_end: assert property (pt_req_o && pt_ack_i |=> !pt_req_o ##[0:1] resp_valid_o)
    else $error("no answer after search");
endmodule // ats_monitor
bind ats_top ats_monitor u_mon (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
  .instr_translate_enable_i(instr_translate_enable_i), .req_ea_i(req_ea_i),
  .data_translate_enable_i(data_translate_enable_i), .req_pc_i(req_pc_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_fetch_i(req_fetch_i),
  .pt_req_o(pt_req_o), .pt_vpn_o(pt_vpn_o), .pt_ack_i(pt_ack_i), .fault_pc_o(fault_pc_o),
  .resp_valid_o(resp_valid_o), .resp_pa_o(resp_pa_o), .saved_status_reg_o(saved_status_reg_o),
  .instr_storage_fault_o(instr_storage_fault_o), .data_storage_fault_o(data_storage_fault_o),
  .data_fault_cause_reg_o(data_fault_cause_reg_o));

// >>> sim/ats_pt_model.sv
// page table responder on the memory side of the search port
`timescale 1ns/10ps
module ats_pt_model (
  // clock and reset
  input  wire        ref_clk_i,
  input  wire        rstn_i,
  // search port
  input  wire        pt_req_i,
  output reg         pt_ack_o,
  output reg         pt_found_o,
  output reg  [19:0] pt_rpn_o,
  output reg         pt_g_o,
  output reg  [1:0]  pt_pp_o,
  // table entry and speed set by the bench
  input  wire        cfg_found_i,
  input  wire [19:0] cfg_rpn_i,
  input  wire        cfg_g_i,
  input  wire [1:0]  cfg_pp_i,
  input  wire [3:0]  cfg_dly_i
);
  reg [3:0] cnt; // cycles spent on this search
  // answer after the set delay; lines scramble otherwise so stale data never looks valid
  always @(posedge ref_clk_i) begin
    cnt <= (!rstn_i || !pt_req_i) ? 4'h0 : cnt + 4'h1;
    if (!rstn_i) begin
      {pt_ack_o, pt_found_o, pt_rpn_o, pt_g_o, pt_pp_o} <= 25'h000_0000;
    end else if (pt_req_i && !pt_ack_o && cnt == cfg_dly_i) begin
      {pt_ack_o, pt_found_o, pt_rpn_o, pt_g_o, pt_pp_o} <=
        {1'b1, cfg_found_i, cfg_rpn_i, cfg_g_i, cfg_pp_i};
    end else begin
      pt_ack_o <= 1'b0;
      {pt_found_o, pt_rpn_o, pt_g_o, pt_pp_o} <= ~{pt_found_o, pt_rpn_o, pt_g_o, pt_pp_o};
    end
  end
endmodule // ats_pt_model

// >>> sim/address_translation_select_tb_top.sv
// self-checking bench for the translation select block
`timescale 1ns/10ps
module address_translation_select_tb_top;
  reg         clk, rstn, ien, den, rv, rf, rs, ru, sw, bw, c_f, c_g;
  reg  [3:0]  si, c_dly;
  reg  [2:0]  bi;
  reg  [31:0] ea, pc, sd, bu, bl, e;
  reg  [19:0] c_rpn;  // table answer for the next search
  reg  [1:0]  c_pp;
  reg  [23:0] vs3;    // identifier of the paged segment
  wire        rdy, ptr, ack, fnd, pg, rsv, isf, dsf;
  wire [39:0] vpn;
  wire [19:0] prpn;
  wire [1:0]  ppp;
  wire [31:0] pa, ssr, dcr, fpc;
  wire [51:0] va;
  integer     n_mismatch, compares, lat, i;
  ats_top dut (.ref_clk_i(clk), .rstn_i(rstn), .instr_translate_enable_i(ien),
    .data_translate_enable_i(den), .req_valid_i(rv), .req_ready_o(rdy), .req_fetch_i(rf),
    .req_store_i(rs), .req_user_i(ru), .req_ea_i(ea), .req_pc_i(pc), .seg_wr_i(sw),
    .seg_idx_i(si), .seg_data_i(sd), .blk_wr_i(bw), .blk_idx_i(bi), .blk_upper_i(bu),
    .blk_lower_i(bl), .pt_req_o(ptr), .pt_vpn_o(vpn), .pt_ack_i(ack), .pt_found_i(fnd),
    .pt_rpn_i(prpn), .pt_g_i(pg), .pt_pp_i(ppp), .resp_valid_o(rsv), .resp_pa_o(pa),
    .resp_va_o(va), .instr_storage_fault_o(isf), .data_storage_fault_o(dsf),
    .saved_status_reg_o(ssr), .data_fault_cause_reg_o(dcr), .fault_pc_o(fpc));
  ats_pt_model u_pt (.ref_clk_i(clk), .rstn_i(rstn), .pt_req_i(ptr), .pt_ack_o(ack),
    .pt_found_o(fnd), .pt_rpn_o(prpn), .pt_g_o(pg), .pt_pp_o(ppp), .cfg_found_i(c_f),
    .cfg_rpn_i(c_rpn), .cfg_g_i(c_g), .cfg_pp_i(c_pp), .cfg_dly_i(c_dly));
  // compare one value, count and report
  task chk(input [63:0] g, input [63:0] x);
    begin
      compares = compares + 1;
      if (g !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  // one segment (s=1) or block map (s=0) load
  task wr(input s, input [3:0] ix, input [31:0] u, input [31:0] l);
    begin
      @(posedge clk) #1;
      {sw, bw, si, bi, sd, bu, bl} = {s, !s, ix, ix[2:0], u, u, l};
      @(posedge clk) #1;
      {sw, bw} = 2'h0;
    end
  endtask
  // one access; k: 0 clean, 1 fetch fault, 2 data fault; cb: cause bit index
  task acc(input f, input s, input u, input [31:0] a, input [31:0] xp, input [1:0] k,
           input integer cb);
    reg [31:0] xc;
    begin
      xc = 32'h0000_0001 << cb;
      @(posedge clk) #1;
      {rv, rf, rs, ru, ea, pc} = {1'b1, f, s, u, a, $urandom};
      @(posedge clk) #1;
      rv = 1'b0;
      lat = 0;
      while (rsv !== 1'b1 && lat < 300) begin
        @(posedge clk) #1;
        lat = lat + 1;
      end
      chk(lat < 300, 1);
      chk({isf, dsf}, {k == 1, k == 2});
      chk(ssr, k == 1 ? xc : 32'h0000_0000);
      chk(dcr, k == 2 ? xc : 32'h0000_0000);
      chk(fpc, k != 0 ? pc : 32'h0000_0000);
      if (k == 0) chk(pa, xp);
    end
  endtask
  // report and end the run
  task complete_run;
    begin
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // watchdog well beyond the expected run
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial begin
    {n_mismatch, compares, c_dly, c_rpn, c_pp} = 0;
    {rstn, ien, den, rv, rf, rs, ru, sw, bw, c_f, c_g, si, bi, ea, pc, sd, bu, bl} = 0;
    void'($urandom(35));
    vs3 = $urandom;
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    wr(1, 1, 32'h8000_0000, 0); // direct-store segment
    wr(1, 2, 32'h1000_0000, 0); // no-execute segment
    wr(1, 3, {8'h20, vs3}, 0);  // user key 1, supervisor key 0
    // translation off over several segments, direct-store and no-execute among them
    for (i = 0; i < 6; i = i + 1) begin
      e = $urandom;
      e[31:28] = i[3:0];
      acc(i[1], i[0], i[2], e, e, 0, 0);
    end
    {ien, den} = 2'h3;
    e = $urandom;
    acc(1, 0, 0, {4'h1, e[27:0]}, 0, 1, 28);
    acc(0, 0, 1, {4'h1, e[27:0]}, 0, 2, 26);
    acc(0, 1, 0, {4'h1, e[27:0]}, 0, 2, 26);
    acc(1, 0, 1, {4'h2, e[27:0]}, 0, 1, 28);
    c_dly = 4'h3;
    acc(0, 0, 0, {4'h3, e[27:0]}, 0, 2, 30);
    acc(1, 0, 0, {4'h3, e[27:0]}, 0, 1, 30);
    {c_f, c_g, c_pp, c_rpn, c_dly} = {2'h2, 2'h2, 24'($urandom)};
    acc(0, 0, 1, {4'h3, e[27:0]}, {c_rpn, e[11:0]}, 0, 0);
    chk(va, {vs3, e[27:0]});
    c_f = 1'b0;
    acc(0, 1, 0, {4'h3, e[27:0]}, {c_rpn, e[11:0]}, 0, 0);
    chk(lat, 1);
    acc(1, 0, 0, {4'h3, e[27:0]}, 0, 1, 30);
    // read-only page: user key 1 store refused, supervisor key 0 store allowed
    e = e ^ 32'h0000_1000;
    {c_f, c_g, c_pp, c_rpn, c_dly} = {2'h2, 2'h1, 24'($urandom)};
    acc(0, 1, 1, {4'h3, e[27:0]}, 0, 2, 27);
    c_f = 1'b0;
    acc(0, 1, 0, {4'h3, e[27:0]}, {c_rpn, e[11:0]}, 0, 0);
    acc(0, 0, 1, {4'h3, e[27:0]}, {c_rpn, e[11:0]}, 0, 0);
    e = e ^ 32'h0000_2000;
    {c_f, c_g, c_pp, c_dly} = {2'h3, 2'h2, 4'h9};
    acc(1, 0, 0, {4'h3, e[27:0]}, 0, 1, 28);
    // key 0 page coded 11: supervisor store refused, user read still allowed
    e = e ^ 32'h0000_4000;
    {c_f, c_g, c_pp, c_dly} = {2'h2, 2'h3, 4'h2};
    acc(0, 1, 0, {4'h3, e[27:0]}, 0, 2, 27);
    c_f = 1'b0;
    acc(0, 0, 1, {4'h3, e[27:0]}, {c_rpn, e[11:0]}, 0, 0);
    // supervisor-only block over the no-execute segment
    e = $urandom;
    e[31:28] = 4'h2;
    wr(0, 0, {e[31:17], 15'h0000, 2'h2}, {c_rpn[14:0], 17'h0_0002});
    acc(1, 0, 0, e, {c_rpn[14:0], e[16:0]}, 0, 0);
    acc(1, 0, 1, e, 0, 1, 28);
    // read-only data block over the direct-store segment
    e[31:28] = 4'h1;
    wr(0, 4, {e[31:17], 15'h0000, 2'h3}, {c_rpn[14:0], 17'h0_0001});
    acc(0, 0, 1, e, {c_rpn[14:0], e[16:0]}, 0, 0);
    acc(0, 1, 0, e, 0, 2, 27);
    // guarded block with no access: guarded wins
    e[31:28] = 4'h5;
    wr(0, 1, {e[31:17], 15'h0000, 2'h3}, {c_rpn[14:0], 17'h0_0008});
    acc(1, 0, 0, e, 0, 1, 28);
    complete_run;
  end
endmodule // address_translation_select_tb_top
